// ===== common/urg_consts.vh
// Register offsets, field positions and reset values of the UART support register block.
// What this block does
// - Carrier status bit inverts pin, loopback uses bit3
// - Scratch byte, resets to all ones
// - Flow thresholds replace modem status when selected
// - Halt level is low nibble times four
// - Resume level is high nibble times four
// - Offset seven shows trigger levels or scratch
// - Transmit trigger low nibble times four, legacy fallback
// - Receive trigger high nibble times four, legacy fallback
// - Timeout interrupt needs one byte and idle line
// - Free transmit spaces counter, 64 when empty
// - Receive fill counter, 64 when full
// - Direction bit one makes pin output
// - State read returns pins, write drives outputs
// - Pin enables ignored for modem upper pins
// - Software reset bit resets device, self clears
// - Select bit makes upper pins modem signals
// - Unlatched change interrupt clears on read or return
// - Latched change holds level until state read
// - Infrared bit picks 3/16 or 1/4 pulse
// - Loopback active while modem control bit four set
`ifndef URG_CONSTS_VH
`define URG_CONSTS_VH
`define URG_OFS_MODEM_CTRL     4'h4
`define URG_OFS_MODEM_STATUS   4'h6
`define URG_OFS_SCRATCH        4'h7
`define URG_OFS_TX_SPACE       4'h8
`define URG_OFS_RX_FILL        4'h9
`define URG_OFS_PIN_DIR        4'hA
`define URG_OFS_PIN_STATE      4'hB
`define URG_OFS_PIN_IRQ_EN     4'hC
`define URG_OFS_PIN_CTRL       4'hE
`define URG_OFS_EXTRA_CTRL     4'hF
`define URG_OFS_ENH_FEATURE    4'h2
`define URG_SCRATCH_RESET      8'hFF
`define URG_BYTE_ZERO          8'h00
`define URG_MCR_SUBSEL_BIT     2
`define URG_MCR_CARRIER_BIT    3
`define URG_MCR_LOOP_BIT       4
`define URG_EFR_ENH_BIT        4
`define URG_PCTL_LATCH_BIT     0
`define URG_PCTL_MODEM_BIT     1
`define URG_PCTL_SWRST_BIT     3
`define URG_EXTRA_FEATURE_CONTROL_IR_BIT        7
`define URG_FIFO_DEPTH         7'h40
`define URG_IRQ_TX_BIT         0
`define URG_IRQ_RX_BIT         1
`define URG_IRQ_TO_BIT         2
`define URG_IRQ_PIN_BIT        3
`endif

// ===== dv/urg_host.sv
// Host model driving byte register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module urg_host (
    input  wire logic       clk,
    output var  logic       wr,
    output var  logic       rd,
    output var  logic [3:0] addr,
    output var  logic [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        wr = 1'h0;
        rd = 1'h0;
        addr = 4'h0;
        wdata = 8'h00;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
        // Released data is scrambled so nothing relies on a stale byte.
        wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/urg_regs_asserts.sv
// Port-level assertions for the UART support register block.
`timescale 1ns/1ps
`default_nettype none
module urg_regs_asserts #(
    parameter DEPTH = 64
) (
    input wire logic       MCLK,
    input wire logic       RESETN,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [6:0] TX_FIFO_COUNT,
    input wire logic [6:0] RX_FIFO_COUNT,
    input wire logic       RX_LINE_IDLE,
    input wire logic       AUTO_RTS_EN,
    input wire logic       SW_FLOW_EN,
    input wire logic       RTS_N,
    input wire logic       SEND_STOP_CHAR,
    input wire logic       IR_QUARTER_PULSE,
    input wire logic       UART_SOFT_RESET,
    input wire logic [3:0] IRQ_STATUS,
    input wire logic       IRQ_N
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // Status lags its inputs and a soft reset wipes state, so level checks wait a few cycles.
    logic [1:0] up_cnt;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN || UART_SOFT_RESET) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    sequence s_rd(a);
        REG_RD && REG_ADDR == a;
    endsequence
    sequence s_wr(a);
        REG_WR && REG_ADDR == a && up_cnt == 2'h3;
    endsequence
    a_rx_fill_read: assert property (s_rd(4'h9) |=> REG_RDATA == {1'h0, $past(RX_FIFO_COUNT)})
        else $error("rx fill count read wrong");
    a_tx_space_read: assert property (s_rd(4'h8) |=>
        REG_RDATA == 8'(DEPTH) - {1'h0, $past(TX_FIFO_COUNT)}) else $error("tx space read wrong");
    a_unmapped_read: assert property (s_rd(4'hD) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_timeout_irq_cause: assert property (up_cnt == 2'h3 |-> IRQ_STATUS[2] ==
        ($past(RX_FIFO_COUNT) != 7'h00 && $past(RX_LINE_IDLE))) else $error("timeout irq wrong");
    a_irq_merge_out: assert property (up_cnt == 2'h3 |-> IRQ_N == !(|IRQ_STATUS) ||
        IRQ_N == !(|$past(IRQ_STATUS))) else $error("irq output not merged");
    a_rts_halt_cause: assert property ($rose(RTS_N) |-> $past(AUTO_RTS_EN))
        else $error("halt without auto flow");
    a_stop_char_pulse: assert property (SEND_STOP_CHAR |-> $past(SW_FLOW_EN) ##1 !SEND_STOP_CHAR)
        else $error("stop char pulse wrong");
    a_soft_reset_pulse: assert property (s_wr(4'hE) ##0 REG_WDATA[3] |->
        ##[1:2] UART_SOFT_RESET ##1 !UART_SOFT_RESET) else $error("soft reset pulse wrong");
    a_ir_mode_select: assert property (s_wr(4'hF) |->
        ##2 IR_QUARTER_PULSE == $past(REG_WDATA[7], 2)) else $error("ir mode not applied");
endmodule
bind urg_regs urg_regs_asserts #(.DEPTH(DEPTH)) i_urg_regs_asserts (
    .MCLK(MCLK), .RESETN(RESETN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TX_FIFO_COUNT(TX_FIFO_COUNT),
    .RX_FIFO_COUNT(RX_FIFO_COUNT), .RX_LINE_IDLE(RX_LINE_IDLE), .AUTO_RTS_EN(AUTO_RTS_EN),
    .SW_FLOW_EN(SW_FLOW_EN), .RTS_N(RTS_N), .SEND_STOP_CHAR(SEND_STOP_CHAR),
    .IR_QUARTER_PULSE(IR_QUARTER_PULSE), .UART_SOFT_RESET(UART_SOFT_RESET),
    .IRQ_STATUS(IRQ_STATUS), .IRQ_N(IRQ_N));
`default_nettype wire

// ===== dv/urg_regs_tb.sv
// Self-checking testbench for the UART support register block.
`timescale 1ns/1ps
`default_nettype none
module urg_regs_tb;
    logic       mclk, resetn, wr, rd, idle, arts, swf, cd_n, rts_n, stc, rsc, irq_q, srst, irq_n;
    logic [3:0] addr, irq_st;
    logic [7:0] wdata, rdata, pin_x, g_in, g_out, g_oe;
    logic [6:0] tx_c, rx_c;
    logic [1:0] ltx, lrx;
    int         miscompares, n_compared;
    assign g_in = (g_oe & g_out) | (~g_oe & pin_x);
    urg_host i_urg_host (.clk(mclk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));
    urg_regs i_urg_regs (.MCLK(mclk), .RESETN(resetn), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .TX_FIFO_COUNT(tx_c),
        .RX_FIFO_COUNT(rx_c), .LEGACY_TX_TRIG(ltx), .LEGACY_RX_TRIG(lrx), .RX_LINE_IDLE(idle),
        .AUTO_RTS_EN(arts), .SW_FLOW_EN(swf), .CARRIER_DETECT_N(cd_n), .GPIO_IN(g_in),
        .GPIO_OUT(g_out), .GPIO_OE(g_oe), .RTS_N(rts_n), .SEND_STOP_CHAR(stc),
        .SEND_RESUME_CHAR(rsc), .IR_QUARTER_PULSE(irq_q), .UART_SOFT_RESET(srst),
        .IRQ_STATUS(irq_st), .IRQ_N(irq_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        i_urg_host.wr_reg(a, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_urg_host.rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic give_verdict;
        $display("compared %0d, miscompared %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_select;
        rdc(4'h7, 8'hFF);
        w(4'h7, 8'h5A);
        w(4'h6, 8'h33);
        rdc(4'h6, 8'h00);
        w(4'h2, 8'h10);
        w(4'h4, 8'h04);
        w(4'h6, 8'h1A);
        w(4'h7, 8'h21);
        rdc(4'h6, 8'h1A);
        rdc(4'h7, 8'h21);
        w(4'h2, 8'h00);
        rdc(4'h7, 8'h5A);
        rdc(4'h6, 8'h00);
        rdc(4'hD, 8'h00);
        w(4'h2, 8'h10);
        $display("select test done");
    endtask
    task automatic t_levels;
        tx_c <= 7'h3D;
        rx_c <= 7'h07;
        wt(4);
        chk({4'h0, irq_st}, 8'h00);
        tx_c <= 7'h3C;
        rx_c <= 7'h08;
        idle <= 1'h1;
        wt(4);
        chk({4'h0, irq_st}, 8'h07);
        chk({7'h0, irq_n}, 8'h00);
        rx_c <= 7'h28;
        wt(4);
        chk({7'h0, rts_n}, 8'h01);
        rx_c <= 7'h05;
        wt(4);
        chk({7'h0, rts_n}, 8'h01);
        rx_c <= 7'h04;
        wt(4);
        chk({7'h0, rts_n}, 8'h00);
        w(4'h7, 8'h00);
        tx_c <= 7'h21;
        rx_c <= 7'h0F;
        idle <= 1'h0;
        wt(4);
        chk({4'h0, irq_st}, 8'h00);
        tx_c <= 7'h20;
        rx_c <= 7'h10;
        wt(4);
        chk({4'h0, irq_st}, 8'h03);
        tx_c <= 7'h00;
        rx_c <= 7'h40;
        rdc(4'h8, 8'h40);
        rdc(4'h9, 8'h40);
        tx_c <= 7'h40;
        rx_c <= 7'h00;
        rdc(4'h8, 8'h00);
        rdc(4'h9, 8'h00);
        tx_c <= 7'h21;
        $display("levels test done");
    endtask
    task automatic t_carrier;
        w(4'h4, 8'h00);
        cd_n <= 1'h0;
        wt(4);
        rdc(4'h6, 8'h80);
        w(4'h4, 8'h18);
        rdc(4'h6, 8'h80);
        w(4'h4, 8'h10);
        rdc(4'h6, 8'h00);
        w(4'h4, 8'h00);
        $display("carrier test done");
    endtask
    task automatic t_pins;
        w(4'hA, 8'h0F);
        w(4'hB, 8'hA5);
        wt(2);
        chk(g_oe, 8'h0F);
        chk(g_out & 8'h0F, 8'h05);
        rdc(4'hB, 8'h05);
        w(4'hC, 8'h10);
        pin_x <= 8'h10;
        wt(6);
        chk({7'h0, irq_st[3]}, 8'h01);
        chk({7'h0, irq_n}, 8'h00);
        pin_x <= 8'h00;
        wt(6);
        chk({7'h0, irq_st[3]}, 8'h00);
        pin_x <= 8'h10;
        wt(6);
        rdc(4'hB, 8'h15);
        wt(3);
        chk({7'h0, irq_st[3]}, 8'h00);
        w(4'hE, 8'h01);
        pin_x <= 8'h00;
        wt(6);
        pin_x <= 8'h10;
        wt(6);
        chk({7'h0, irq_st[3]}, 8'h01);
        rdc(4'hB, 8'h05);
        wt(3);
        chk({7'h0, irq_st[3]}, 8'h00);
        w(4'hA, 8'hFF);
        w(4'hE, 8'h02);
        wt(2);
        chk(g_oe, 8'h0F);
        w(4'hA, 8'h0F);
        pin_x <= 8'h00;
        wt(6);
        chk({7'h0, irq_st[3]}, 8'h00);
        $display("pin test done");
    endtask
    task automatic t_mode_reset;
        w(4'hF, 8'h80);
        wt(2);
        chk({7'h0, irq_q}, 8'h01);
        w(4'hF, 8'h00);
        wt(2);
        chk({7'h0, irq_q}, 8'h00);
        w(4'hE, 8'h08);
        wt(4);
        rdc(4'hE, 8'h00);
        rdc(4'h7, 8'h5A);
        chk(g_oe, 8'h00);
        $display("mode and reset test done");
    endtask
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict;
    end
    initial begin
        {resetn, idle, arts, swf, tx_c, rx_c, ltx, lrx, pin_x} = '0;
        cd_n = 1'h1;
        wt(2);
        resetn <= 1'h1;
        arts <= 1'h1;
        swf <= 1'h1;
        ltx <= 2'h2;
        lrx <= 2'h1;
        wt(2);
        t_select;
        t_levels;
        t_carrier;
        t_pins;
        t_mode_reset;
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== rtl/urg_pin_port.v
// General-purpose pin port with change detection and optional latching.
`timescale 1ns/1ps
`default_nettype none
module urg_pin_port #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             soft_rst,
    input  wire [WIDTH-1:0] pin_sync,
    input  wire [WIDTH-1:0] dir,
    input  wire [WIDTH-1:0] irq_en,
    input  wire             latch_on,
    input  wire             modem_sel,
    input  wire             state_wr,
    input  wire [WIDTH-1:0] wdata,
    input  wire             state_rd,
    output reg  [WIDTH-1:0] out_reg,
    output wire [WIDTH-1:0] state_view,
    output wire             irq
);
    reg  [WIDTH-1:0] ref_reg;
    reg  [WIDTH-1:0] cap_reg;
    reg  [WIDTH-1:0] pend_reg;
    wire [WIDTH-1:0] is_in   = ~dir;
    wire [WIDTH-1:0] changed = (pin_sync ^ ref_reg) & is_in;
    // A latched bit ignores further edges until it is read, so a return keeps the capture.
    wire [WIDTH-1:0] new_chg = changed & ~pend_reg;
    wire [WIDTH-1:0] en_mask = modem_sel ? {4'h0, irq_en[3:0]} : irq_en;

    // Latched inputs show the captured level; unlatched inputs show the live pin.
    assign state_view = (dir & out_reg) | (is_in & (latch_on ? cap_reg : pin_sync));
    assign irq = |(pend_reg & en_mask);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg  <= {WIDTH{1'b0}};
            ref_reg  <= {WIDTH{1'b0}};
            cap_reg  <= {WIDTH{1'b0}};
            pend_reg <= {WIDTH{1'b0}};
        end else if (soft_rst) begin
            out_reg  <= {WIDTH{1'b0}};
            ref_reg  <= pin_sync;
            cap_reg  <= pin_sync;
            pend_reg <= {WIDTH{1'b0}};
        end else begin
            if (state_wr)
                out_reg <= wdata;
            if (latch_on) begin
                // A new change in the read cycle still sets the flag.
                pend_reg <= (state_rd ? {WIDTH{1'b0}} : pend_reg) | new_chg;
                cap_reg  <= state_rd ? pin_sync :
                            ((cap_reg & ~new_chg) | (pin_sync & new_chg));
                ref_reg  <= state_rd ? pin_sync :
                            ((ref_reg & ~new_chg) | (pin_sync & new_chg));
            end else begin
                // The reference moves only at a read, so a return to it clears the flag.
                pend_reg <= changed;
                cap_reg  <= pin_sync;
                if (state_rd)
                    ref_reg <= pin_sync;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/urg_regs.v
// UART support registers: thresholds, trigger levels, counters, scratch, modem status and pins.
`timescale 1ns/1ps
`default_nettype none
`include "urg_consts.vh"
module urg_regs #(
    parameter DEPTH = 64
) (
    input  wire       MCLK,
    input  wire       RESETN,
    input  wire       REG_WR,
    input  wire       REG_RD,
    input  wire [3:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    output reg  [7:0] REG_RDATA,
    input  wire [6:0] TX_FIFO_COUNT,
    input  wire [6:0] RX_FIFO_COUNT,
    input  wire [1:0] LEGACY_TX_TRIG,
    input  wire [1:0] LEGACY_RX_TRIG,
    input  wire       RX_LINE_IDLE,
    input  wire       AUTO_RTS_EN,
    input  wire       SW_FLOW_EN,
    input  wire       CARRIER_DETECT_N,
    input  wire [7:0] GPIO_IN,
    output reg  [7:0] GPIO_OUT,
    output reg  [7:0] GPIO_OE,
    output reg        RTS_N,
    output reg        SEND_STOP_CHAR,
    output reg        SEND_RESUME_CHAR,
    output reg        IR_QUARTER_PULSE,
    output reg        UART_SOFT_RESET,
    output reg  [3:0] IRQ_STATUS,
    output reg        IRQ_N
);
    reg  [7:0] modem_control_reg;
    reg  [7:0] enhanced_feature_reg;
    reg  [7:0] scratch_byte_reg;
    reg  [7:0] flow_threshold_levels_reg;
    reg  [7:0] fifo_trigger_levels_reg;
    reg  [7:0] pin_direction_reg;
    reg  [7:0] pin_change_irq_enable_reg;
    reg  [7:0] pin_control_reg;
    reg  [7:0] extra_feature_control_reg;
    reg        soft_rst_reg;
    reg        halted_reg;
    reg        cd_meta_reg;
    reg        cd_sync_reg;
    reg  [7:0] gp_meta_reg;
    reg  [7:0] gp_sync_reg;
    reg  [7:0] rdata_next;
    wire [7:0] pin_out;
    wire [7:0] pin_view;
    wire       pin_irq;

    // Nibble times four, giving the level in characters.
    function [6:0] nib_level;
        input [3:0] nib;
        begin
            nib_level = {1'b0, nib, 2'b00};
        end
    endfunction

    // Legacy two-bit trigger selection mapped to a character count.
    function [6:0] legacy_level;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    legacy_level = 7'h08;
                2'h1:    legacy_level = 7'h10;
                2'h2:    legacy_level = 7'h20;
                default: legacy_level = 7'h38;
            endcase
        end
    endfunction

    wire       enh_on    = enhanced_feature_reg[`URG_EFR_ENH_BIT];
    wire       sub_sel   = modem_control_reg[`URG_MCR_SUBSEL_BIT];
    wire       alt_map   = enh_on & sub_sel;
    wire       loop_on   = modem_control_reg[`URG_MCR_LOOP_BIT];
    wire       modem_sel = pin_control_reg[`URG_PCTL_MODEM_BIT];
    localparam [31:0] depth_word = DEPTH;
    wire [6:0] tx_space  = depth_word[6:0] - TX_FIFO_COUNT;
    wire [6:0] halt_lvl  = nib_level(flow_threshold_levels_reg[3:0]);
    wire [6:0] resume_lvl = nib_level(flow_threshold_levels_reg[7:4]);
    wire [6:0] tx_trig = (fifo_trigger_levels_reg[3:0] == 4'h0) ?
                         legacy_level(LEGACY_TX_TRIG) :
                         nib_level(fifo_trigger_levels_reg[3:0]);
    wire [6:0] rx_trig = (fifo_trigger_levels_reg[7:4] == 4'h0) ?
                         legacy_level(LEGACY_RX_TRIG) :
                         nib_level(fifo_trigger_levels_reg[7:4]);
    // When the upper pins carry modem signals, carrier detect comes in on pin five.
    wire       cd_pin    = modem_sel ? gp_sync_reg[5] : cd_sync_reg;
    wire       cd_status = loop_on ? modem_control_reg[`URG_MCR_CARRIER_BIT] : ~cd_pin;
    wire       wr_ok     = REG_WR & ~soft_rst_reg;
    wire       rd_state  = REG_RD & (REG_ADDR == `URG_OFS_PIN_STATE);
    wire       stop_hit  = RX_FIFO_COUNT >= halt_lvl;
    wire       go_hit    = RX_FIFO_COUNT <= resume_lvl;

    urg_pin_port #(
        .WIDTH      (8)
    ) u_pins (
        .clk        (MCLK),
        .rst_n      (RESETN),
        .soft_rst   (soft_rst_reg),
        .pin_sync   (gp_sync_reg),
        .dir        (pin_direction_reg),
        .irq_en     (pin_change_irq_enable_reg),
        .latch_on   (pin_control_reg[`URG_PCTL_LATCH_BIT]),
        .modem_sel  (modem_sel),
        .state_wr   (wr_ok & (REG_ADDR == `URG_OFS_PIN_STATE)),
        .wdata      (REG_WDATA),
        .state_rd   (rd_state),
        .out_reg    (pin_out),
        .state_view (pin_view),
        .irq        (pin_irq)
    );

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cd_meta_reg <= 1'b1;
            cd_sync_reg <= 1'b1;
            gp_meta_reg <= 8'h00;
            gp_sync_reg <= 8'h00;
        end else begin
            cd_meta_reg <= CARRIER_DETECT_N;
            cd_sync_reg <= cd_meta_reg;
            gp_meta_reg <= GPIO_IN;
            gp_sync_reg <= gp_meta_reg;
        end
    end

    always @* begin
        rdata_next = `URG_BYTE_ZERO;
        case (REG_ADDR)
            `URG_OFS_MODEM_CTRL:   rdata_next = modem_control_reg;
            `URG_OFS_ENH_FEATURE:  rdata_next = enhanced_feature_reg;
            `URG_OFS_MODEM_STATUS: rdata_next = alt_map ? flow_threshold_levels_reg :
                                                {cd_status, 7'h00};
            `URG_OFS_SCRATCH:      rdata_next = alt_map ? fifo_trigger_levels_reg :
                                                scratch_byte_reg;
            `URG_OFS_TX_SPACE:     rdata_next = {1'b0, tx_space};
            `URG_OFS_RX_FILL:      rdata_next = {1'b0, RX_FIFO_COUNT};
            `URG_OFS_PIN_DIR:      rdata_next = pin_direction_reg;
            `URG_OFS_PIN_STATE:    rdata_next = pin_view;
            `URG_OFS_PIN_IRQ_EN:   rdata_next = pin_change_irq_enable_reg;
            `URG_OFS_PIN_CTRL:     rdata_next = pin_control_reg;
            `URG_OFS_EXTRA_CTRL:   rdata_next = extra_feature_control_reg;
            default:               rdata_next = `URG_BYTE_ZERO;
        endcase
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            modem_control_reg         <= 8'h00;
            enhanced_feature_reg      <= 8'h00;
            scratch_byte_reg          <= `URG_SCRATCH_RESET;
            flow_threshold_levels_reg <= 8'h00;
            fifo_trigger_levels_reg   <= 8'h00;
            pin_direction_reg         <= 8'h00;
            pin_change_irq_enable_reg <= 8'h00;
            pin_control_reg           <= 8'h00;
            extra_feature_control_reg <= 8'h00;
            soft_rst_reg              <= 1'b0;
        end else if (soft_rst_reg) begin
            // Scratch content is kept: only RESETN low restores all ones.
            modem_control_reg         <= 8'h00;
            enhanced_feature_reg      <= 8'h00;
            flow_threshold_levels_reg <= 8'h00;
            fifo_trigger_levels_reg   <= 8'h00;
            pin_direction_reg         <= 8'h00;
            pin_change_irq_enable_reg <= 8'h00;
            pin_control_reg           <= 8'h00;
            extra_feature_control_reg <= 8'h00;
            soft_rst_reg              <= 1'b0;
        end else if (wr_ok) begin
            case (REG_ADDR)
                `URG_OFS_MODEM_CTRL:   modem_control_reg <= enh_on ? REG_WDATA :
                    {modem_control_reg[7:5], REG_WDATA[4:3], modem_control_reg[2],
                     REG_WDATA[1:0]};
                `URG_OFS_ENH_FEATURE:  enhanced_feature_reg <= REG_WDATA;
                `URG_OFS_MODEM_STATUS: if (alt_map)
                    flow_threshold_levels_reg <= REG_WDATA;
                `URG_OFS_SCRATCH: begin
                    if (alt_map)
                        fifo_trigger_levels_reg <= REG_WDATA;
                    else
                        scratch_byte_reg <= REG_WDATA;
                end
                `URG_OFS_PIN_DIR:      pin_direction_reg <= REG_WDATA;
                `URG_OFS_PIN_IRQ_EN:   pin_change_irq_enable_reg <= REG_WDATA;
                `URG_OFS_PIN_CTRL: begin
                    pin_control_reg <= {4'h0, 1'b0, 1'b0, REG_WDATA[1:0]};
                    soft_rst_reg    <= REG_WDATA[`URG_PCTL_SWRST_BIT];
                end
                `URG_OFS_EXTRA_CTRL:   extra_feature_control_reg <= REG_WDATA;
                default: ;
            endcase
        end
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA        <= 8'h00;
            GPIO_OUT         <= 8'h00;
            GPIO_OE          <= 8'h00;
            RTS_N            <= 1'b0;
            halted_reg       <= 1'b0;
            SEND_STOP_CHAR   <= 1'b0;
            SEND_RESUME_CHAR <= 1'b0;
            IR_QUARTER_PULSE <= 1'b0;
            UART_SOFT_RESET  <= 1'b0;
            IRQ_STATUS       <= 4'h0;
            IRQ_N            <= 1'b1;
        end else begin
            if (REG_RD)
                REG_RDATA <= rdata_next;
            GPIO_OUT <= pin_out;
            GPIO_OE  <= modem_sel ? {4'h0, pin_direction_reg[3:0]} : pin_direction_reg;
            // Hysteresis between halt and resume keeps the stop state from chattering.
            if (stop_hit & ~halted_reg)
                halted_reg <= 1'b1;
            else if (go_hit & halted_reg & ~stop_hit)
                halted_reg <= 1'b0;
            RTS_N            <= AUTO_RTS_EN & halted_reg;
            SEND_STOP_CHAR   <= SW_FLOW_EN & stop_hit & ~halted_reg;
            SEND_RESUME_CHAR <= SW_FLOW_EN & go_hit & halted_reg & ~stop_hit;
            IR_QUARTER_PULSE <= extra_feature_control_reg[`URG_EXTRA_FEATURE_CONTROL_IR_BIT];
            UART_SOFT_RESET  <= soft_rst_reg;
            IRQ_STATUS[`URG_IRQ_TX_BIT]  <= tx_space >= tx_trig;
            IRQ_STATUS[`URG_IRQ_RX_BIT]  <= RX_FIFO_COUNT >= rx_trig;
            IRQ_STATUS[`URG_IRQ_TO_BIT]  <= (RX_FIFO_COUNT != 7'h00) & RX_LINE_IDLE;
            IRQ_STATUS[`URG_IRQ_PIN_BIT] <= pin_irq;
            IRQ_N <= ~((tx_space >= tx_trig) | (RX_FIFO_COUNT >= rx_trig) |
                       ((RX_FIFO_COUNT != 7'h00) & RX_LINE_IDLE) | pin_irq);
        end
    end
endmodule
`default_nettype wire
